// *** design/plb_pkg.sv ***
// Constants, pin groups and request carriers shared by the local bus bridge.
// Assumes a single 20 MHz clock shared with the PCI core and the register file.
package plb_pkg;

	// Clock and timer figures; cycle counts derive from the printed times
	localparam int CLK_PERIOD_NS = 50;
	localparam int WAIT_TIME_NS = 400;
	localparam int LAT_TIME_NS = 1000;
	localparam int WAIT_CYC_I = (WAIT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : WAIT_TIME_NS / CLK_PERIOD_NS;
	localparam int LAT_CYC_I = (LAT_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : LAT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [4:0] WAIT_CYC = 5'(WAIT_CYC_I);
	localparam logic [4:0] LAT_CYC = 5'(LAT_CYC_I);
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;

	// Window decode: 8 kByte pages in the low 15 address bits
	localparam int PAGE_LSB = 13;
	localparam logic [1:0] PAGE_INVALID = 2'h3;
	localparam logic [1:0] CS_PAGE0 = 2'h2;
	localparam logic [1:0] CS_PAGE1 = 2'h1;
	localparam logic [1:0] CS_PAGE2 = 2'h0;
	localparam int WADDR_HI = 12;
	localparam int WADDR_LO = 2;

	// Byte enable patterns, active low
	localparam logic [3:0] BE_B0 = 4'hE;
	localparam logic [3:0] BE_B1 = 4'hD;
	localparam logic [3:0] BE_B2 = 4'hB;
	localparam logic [3:0] BE_B3 = 4'h7;
	localparam logic [3:0] BE_H0 = 4'hC;
	localparam logic [3:0] BE_H2 = 4'h3;

	// Static configuration, held stable while the local bus is active
	typedef struct packed {
		logic local_master_enable_bit;
		logic second_window_enable_bit;
		logic style_ds;
		logic port16;
		logic swap_dis;
	} plb_cfg_t;

	// Access into the second window, presented by the PCI target
	typedef struct packed {
		logic valid;
		logic write;
		logic [14:0] addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} plb_mreq_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic error;
		logic [31:0] rdata;
	} plb_mrsp_t;

	// Internal register file access made by a local processor
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [15:0] wdata;
	} plb_rreq_t;

	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} plb_rrsp_t;

	// Local bus pins as seen from outside
	typedef struct packed {
		logic slave_chip_select_n;
		logic read_strobe_n;
		logic write_strobe_n;
		logic cycle_ready_n;
		logic bus_hold_acknowledge;
		logic read_write_direction;
		logic data_strobe_n;
		logic data_acknowledge_n;
		logic bus_grant_in_n;
		logic bus_grant_acknowledge_n;
		logic [11:0] local_address_lines;
		logic [15:0] local_data_lines;
	} plb_pin_in_t;

	typedef struct packed {
		logic [11:0] local_address_lines;
		logic local_address_bit0;
		logic [15:0] local_data_lines;
		logic page_select_one;
		logic page_select_two;
		logic read_strobe_n;
		logic write_strobe_n;
		logic cycle_ready_n;
		logic bus_hold_request;
		logic byte_high_enable_n;
		logic transfer_size_bit;
		logic read_write_direction;
		logic data_strobe_n;
		logic data_acknowledge_n;
		logic bus_request_out_n;
		logic bus_grant_acknowledge_n;
	} plb_pin_out_t;

	// Output enables, high while the bridge drives the pin group
	typedef struct packed {
		logic addr;
		logic data;
		logic strobe_cmd;
		logic ds_cmd;
		logic cycle_ready;
		logic data_ack;
		logic grant_ack;
	} plb_pin_oe_t;

endpackage : plb_pkg

// *** design/plb_lane_map.sv ***
// Byte enable to local address, lane and size mapping for both bus styles.
// Purely combinational; the caller registers whatever reaches a pin.
`timescale 1ns/1ps
`default_nettype none
module plb_lane_map (
	input wire logic [3:0] i_be_n,
	input wire logic [31:0] i_wdata,
	input wire logic [15:0] i_rd16,
	input wire logic i_style_ds,
	input wire logic i_port16,
	input wire logic i_swap_dis,
	output logic o_valid,
	output logic [1:0] o_la,
	output logic o_sel,
	output logic [15:0] o_wd16,
	output logic [31:0] o_rd32
);
	import plb_pkg::*;

	// Byte of a word at a lane index
	function automatic logic [7:0] plb_pick(input logic [31:0] w, input logic [1:0] i);
		plb_pick = w[i*8 +: 8];
	endfunction : plb_pick

	// Word holding one byte at a lane index, zero elsewhere
	function automatic logic [31:0] plb_put(input logic [7:0] b, input logic [1:0] i);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[i*8 +: 8] = b;
		plb_put = r;
	endfunction : plb_put

	logic [1:0] idx;
	logic [1:0] idx_n;
	logic half;
	logic swap;
	logic lane_hi;
	logic [7:0] lo_b;
	logic [7:0] hi_b;
	logic [7:0] rlo;
	logic [7:0] rhi;

	// Pattern decode; halfwords exist only on a 16-bit port
	always_comb begin
		idx = 2'h0;
		half = 1'b0;
		o_valid = 1'b1;
		case (i_be_n)
			BE_B0: idx = 2'h0;
			BE_B1: idx = 2'h1;
			BE_B2: idx = 2'h2;
			BE_B3: idx = 2'h3;
			BE_H0: begin
				half = 1'b1;
				o_valid = i_port16;
			end
			BE_H2: begin
				idx = 2'h2;
				half = 1'b1;
				o_valid = i_port16;
			end
			default: o_valid = 1'b0; // see RL16
		endcase
	end

	// Lane steering; the swap disable acts on halfwords only, single bytes keep their lanes
	always_comb begin
		idx_n = 2'(idx + 2'h1);
		swap = i_port16 & i_style_ds & ~i_swap_dis; // see RL22
		lane_hi = i_port16 ? (idx[0] ^ i_style_ds) : i_style_ds; // see RL14 see RL21
		lo_b = plb_pick(i_wdata, idx);
		hi_b = plb_pick(i_wdata, idx_n);
		o_la = idx;
		rlo = swap ? i_rd16[15:8] : i_rd16[7:0];
		rhi = swap ? i_rd16[7:0] : i_rd16[15:8];
		if (half) begin
			o_sel = 1'b0; // see RL15 see RL22
			o_wd16 = swap ? {lo_b, hi_b} : {hi_b, lo_b};
			o_rd32 = plb_put(rlo, idx) | plb_put(rhi, idx_n);
		end else begin
			// Strobe style: high enable only for odd bytes on a 16-bit port
			o_sel = (i_style_ds | ~i_port16) ? 1'b1 : ~idx[0]; // see RL15
			o_wd16 = lane_hi ? {lo_b, 8'h00} : {8'h00, lo_b};
			o_rd32 = plb_put(lane_hi ? i_rd16[15:8] : i_rd16[7:0], idx);
		end
	end

endmodule : plb_lane_map
`default_nettype wire

// *** design/plb_bridge.sv ***
// Local microprocessor bus bridge: slave access to internal registers and
// master cycles from the second PCI memory window onto the local bus.
// Assumes the PCI target has already decoded the window hit and holds cfg static.
//
// What this block does
// RL1: Window splits into 8 kByte pages; the first three drive their own page select pattern, the fourth is refused.
// RL2: Master cycles run only with the local master enable bit set.
// RL3: Second window is off after reset until its enable bit is set.
// RL4: Local clock output is the system clock passed straight through.
// RL5: Local bus is demultiplexed: twelve word address lines, sixteen data lines.
// RL6: Strobe-style processor sets address, selects, then strobes read or write.
// RL7: Strobe-style slave asserts ready low once register data is valid.
// RL8: After the strobe, release data, drive ready high, float it on deselect.
// RL9: Back-to-back slave cycles are accepted while the slave select stays low.
// RL10: Strobe-style master requests the bus with hold for each window access.
// RL11: On hold acknowledge, latency timer starts; hold stays until both the transfer and the timer have ended.
// RL12: Master drives address, high enable, page selects, then the read or write strobe.
// RL13: Strobe-style master cycle ends on ready or wait timer expiry.
// RL14: Strobe-style 8-bit port: byte index on low address, byte on low lane.
// RL15: Strobe-style 16-bit port: odd bytes high lane, halfwords at 00 and 10.
// RL16: Unlisted byte enable patterns run no cycle and report an access error.
// RL17: Data-strobe processor sets address, select and direction, then data strobe.
// RL18: Data-strobe slave acknowledges low, releases on strobe end, floats on deselect.
// RL19: Data-strobe master arbitrates with request, grant and grant acknowledge first.
// RL20: Data-strobe master drives address, size, select, direction, then data strobe.
// RL21: Data-strobe 8-bit port: byte index on low address, byte on high lane.
// RL22: Data-strobe 16-bit port swaps lanes, halfwords size zero; the halfword swap can be disabled.
// RL23: Bus style, port width and swap disable come from static settings.
`timescale 1ns/1ps
`default_nettype none
module plb_bridge (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire plb_pkg::plb_cfg_t i_cfg,
	input wire plb_pkg::plb_mreq_t i_mreq,
	output plb_pkg::plb_mrsp_t o_mrsp,
	output plb_pkg::plb_rreq_t o_rreq,
	input wire plb_pkg::plb_rrsp_t i_rrsp,
	input wire plb_pkg::plb_pin_in_t i_pin,
	output plb_pkg::plb_pin_out_t o_pin,
	output plb_pkg::plb_pin_oe_t o_oe,
	output logic o_local_clock_out
);
	import plb_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_ARB = 3'b001,
		M_ADDR = 3'b010,
		M_STRB = 3'b011,
		M_END = 3'b100,
		M_HELD = 3'b101
	} plb_mst_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_REG = 2'b01,
		S_DATA = 2'b10
	} plb_slv_t;

	typedef struct packed {
		plb_pin_in_t sync1;
		plb_pin_in_t sync2;
		plb_pin_out_t pin;
		plb_pin_oe_t oe;
		plb_mst_t mst;
		plb_slv_t slv;
		logic [4:0] wait_cnt;
		logic [4:0] lat_cnt;
		plb_mreq_t req;
		plb_mrsp_t rsp;
		plb_rreq_t rreq;
	} plb_state_t;

	plb_state_t s_q;
	plb_state_t s_d;
	plb_mreq_t map_req;
	logic map_valid;
	logic [1:0] map_la;
	logic map_sel;
	logic [15:0] map_wd16;
	logic [31:0] map_rd32;
	logic take;
	logic refuse;
	logic ready_in;
	logic slv_strobe;

	// Reset image: strobes and selects idle high, address, data and hold request low, nothing driven
	localparam plb_state_t RST_STATE = '{
		sync1: '1,
		sync2: '1,
		pin: '{local_address_lines: 12'h000, local_address_bit0: 1'b0,
			local_data_lines: 16'h0000, page_select_one: 1'b1, page_select_two: 1'b1,
			bus_hold_request: 1'b0, byte_high_enable_n: 1'b1, transfer_size_bit: 1'b1,
			default: 1'b1},
		oe: '0,
		mst: M_IDLE,
		slv: S_IDLE,
		wait_cnt: CNT_ZERO,
		lat_cnt: CNT_ZERO,
		req: '0,
		rsp: '0,
		rreq: '0
	};

	// The clock is fed out untouched so local parts share the bridge's timing
	assign o_local_clock_out = i_clk; // see RL4

	// Mapping follows the live request while idle, the held one afterwards
	assign map_req = (s_q.mst == M_IDLE || s_q.mst == M_HELD) ? i_mreq : s_q.req;

	plb_lane_map u_map (
		.i_be_n(map_req.be_n),
		.i_wdata(map_req.wdata),
		.i_rd16(s_q.sync2.local_data_lines),
		.i_style_ds(i_cfg.style_ds), // see RL23
		.i_port16(i_cfg.port16),
		.i_swap_dis(i_cfg.swap_dis),
		.o_valid(map_valid),
		.o_la(map_la),
		.o_sel(map_sel),
		.o_wd16(map_wd16),
		.o_rd32(map_rd32)
	);

	// Request screening: a refused access answers at once and never touches the bus
	always_comb begin
		take = i_mreq.valid && (s_q.mst == M_IDLE || s_q.mst == M_HELD);
		refuse = !i_cfg.local_master_enable_bit // see RL2
			|| !i_cfg.second_window_enable_bit // see RL3
			|| !map_valid // see RL16
			|| map_req.addr[14:PAGE_LSB] == PAGE_INVALID; // see RL1
		ready_in = i_cfg.style_ds ? !s_q.sync2.data_acknowledge_n : !s_q.sync2.cycle_ready_n;
		slv_strobe = i_cfg.style_ds ? !s_q.sync2.data_strobe_n
			: (!s_q.sync2.read_strobe_n || !s_q.sync2.write_strobe_n);
	end

	// Next-state logic for master and slave engines
	always_comb begin
		s_d = s_q;
		s_d.sync1 = i_pin;
		s_d.sync2 = s_q.sync1;
		s_d.rsp.done = 1'b0;
		s_d.rsp.error = 1'b0;
		s_d.rreq.valid = 1'b0;
		if (s_q.lat_cnt != CNT_ZERO) begin
			s_d.lat_cnt = 5'(s_q.lat_cnt - CNT_ONE);
		end
		case (s_q.mst)
			M_IDLE, M_HELD: begin
				if (take && refuse) begin
					s_d.rsp.done = 1'b1;
					s_d.rsp.error = 1'b1;
				end else if (take) begin
					s_d.req = i_mreq;
					s_d.rsp.busy = 1'b1;
					// A bus still held from the last access skips arbitration
					s_d.mst = (s_q.mst == M_HELD) ? M_ADDR : M_ARB;
				end else if (s_q.mst == M_HELD && s_q.lat_cnt == CNT_ZERO) begin
					s_d.pin.bus_hold_request = 1'b0; // see RL11
					s_d.pin.bus_grant_acknowledge_n = 1'b1;
					s_d.oe.grant_ack = 1'b0;
					s_d.mst = M_IDLE;
				end
			end
			M_ARB: begin
				if (!i_cfg.style_ds) begin
					s_d.pin.bus_hold_request = 1'b1; // see RL10
					if (s_q.sync2.bus_hold_acknowledge) begin
						s_d.lat_cnt = LAT_CYC; // see RL11
						s_d.mst = M_ADDR;
					end
				end else begin
					s_d.pin.bus_request_out_n = 1'b0; // see RL19
					// Take the bus only once the previous owner has let go
					if (!s_q.sync2.bus_grant_in_n && s_q.sync2.bus_grant_acknowledge_n) begin
						s_d.pin.bus_request_out_n = 1'b1;
						s_d.pin.bus_grant_acknowledge_n = 1'b0;
						s_d.oe.grant_ack = 1'b1;
						s_d.lat_cnt = LAT_CYC;
						s_d.mst = M_ADDR;
					end
				end
			end
			M_ADDR: begin
				// Address phase first; strobes follow one cycle later
				s_d.pin.local_address_lines = {s_q.req.addr[WADDR_HI:WADDR_LO], map_la[1]}; // see RL5
				s_d.pin.local_address_bit0 = map_la[0];
				s_d.pin.byte_high_enable_n = map_sel; // see RL12
				s_d.pin.transfer_size_bit = map_sel; // see RL20
				case (s_q.req.addr[14:PAGE_LSB]) // see RL1
					2'h0: {s_d.pin.page_select_two, s_d.pin.page_select_one} = CS_PAGE0;
					2'h1: {s_d.pin.page_select_two, s_d.pin.page_select_one} = CS_PAGE1;
					default: {s_d.pin.page_select_two, s_d.pin.page_select_one} = CS_PAGE2;
				endcase
				s_d.pin.read_write_direction = !s_q.req.write;
				s_d.pin.local_data_lines = map_wd16;
				s_d.oe.addr = 1'b1;
				s_d.oe.data = s_q.req.write;
				s_d.oe.strobe_cmd = !i_cfg.style_ds;
				s_d.oe.ds_cmd = i_cfg.style_ds;
				s_d.wait_cnt = WAIT_CYC;
				s_d.mst = M_STRB;
			end
			M_STRB: begin
				if (!i_cfg.style_ds) begin
					s_d.pin.read_strobe_n = s_q.req.write; // see RL12
					s_d.pin.write_strobe_n = !s_q.req.write;
				end else begin
					s_d.pin.data_strobe_n = 1'b0; // see RL20
				end
				s_d.wait_cnt = 5'(s_q.wait_cnt - CNT_ONE);
				// Ready from the target or our own wait timer, whichever is first
				if ((ready_in && s_q.wait_cnt != WAIT_CYC) || s_q.wait_cnt == CNT_ONE) begin // see RL13
					s_d.rsp.rdata = s_q.req.write ? s_q.rsp.rdata : map_rd32;
					s_d.pin.read_strobe_n = 1'b1;
					s_d.pin.write_strobe_n = 1'b1;
					s_d.pin.data_strobe_n = 1'b1;
					s_d.mst = M_END;
				end
			end
			M_END: begin
				// Release the cycle but keep bus ownership until latency expires
				s_d.oe.addr = 1'b0;
				s_d.oe.data = 1'b0;
				s_d.oe.strobe_cmd = 1'b0;
				s_d.oe.ds_cmd = 1'b0;
				s_d.pin.page_select_one = 1'b1;
				s_d.pin.page_select_two = 1'b1;
				s_d.rsp.done = 1'b1;
				s_d.rsp.busy = 1'b0;
				s_d.mst = M_HELD;
			end
			default: s_d.mst = M_IDLE;
		endcase
		// Slave engine; only starts a cycle while this bridge does not own the local bus
		case (s_q.slv)
			S_IDLE: begin
				if (s_q.mst == M_IDLE && !s_q.sync2.slave_chip_select_n) begin
					s_d.oe.cycle_ready = !i_cfg.style_ds;
					s_d.oe.data_ack = i_cfg.style_ds;
					if (slv_strobe) begin // see RL9
						s_d.rreq.valid = 1'b1;
						s_d.rreq.write = i_cfg.style_ds ? !s_q.sync2.read_write_direction
							: !s_q.sync2.write_strobe_n;
						s_d.rreq.addr = s_q.sync2.local_address_lines;
						s_d.rreq.wdata = s_q.sync2.local_data_lines;
						s_d.slv = S_REG;
					end
				end else begin
					s_d.oe.cycle_ready = 1'b0; // see RL8 see RL18
					s_d.oe.data_ack = 1'b0;
				end
			end
			S_REG: begin
				if (i_rrsp.ack) begin
					s_d.pin.local_data_lines = i_rrsp.rdata;
					s_d.oe.data = !s_q.rreq.write;
					s_d.pin.cycle_ready_n = i_cfg.style_ds; // see RL7
					s_d.pin.data_acknowledge_n = !i_cfg.style_ds; // see RL18
					s_d.slv = S_DATA;
				end
			end
			S_DATA: begin
				if (!slv_strobe) begin
					s_d.oe.data = 1'b0; // see RL8 see RL18
					s_d.pin.cycle_ready_n = 1'b1;
					s_d.pin.data_acknowledge_n = 1'b1;
					s_d.slv = S_IDLE;
				end
			end
			default: s_d.slv = S_IDLE;
		endcase
	end

	// One register for the whole state; reset loads constants only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pin = s_q.pin;
	assign o_oe = s_q.oe;
	assign o_mrsp = s_q.rsp;
	assign o_rreq = s_q.rreq;

	localparam int A_WAIT_MAX = 10;

	default clocking a_clk @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	page_select_map_a: assert property ((s_q.mst == M_STRB && s_q.req.addr[14:PAGE_LSB] == 2'h1)
		|-> !o_pin.page_select_two && o_pin.page_select_one) // see RL1
		else $error("page one select pattern wrong");
	master_gate_a: assert property ((s_q.mst == M_IDLE && i_mreq.valid
		&& !i_cfg.local_master_enable_bit) |=> o_mrsp.done && o_mrsp.error
		&& s_q.mst == M_IDLE) // see RL2
		else $error("disabled master started a cycle");
	window_gate_a: assert property ((s_q.mst == M_IDLE && i_mreq.valid
		&& !i_cfg.second_window_enable_bit) |=> ##1 s_q.mst == M_IDLE && !o_oe.addr) // see RL3
		else $error("disabled window reached the bus");
	slave_ready_a: assert property ((s_q.slv == S_REG && i_rrsp.ack && !i_cfg.style_ds)
		|=> !o_pin.cycle_ready_n && s_q.slv == S_DATA) // see RL7
		else $error("ready not asserted after register access");
	slave_release_a: assert property ((s_q.slv == S_DATA && !slv_strobe)
		|=> !o_oe.data && o_pin.cycle_ready_n && o_pin.data_acknowledge_n) // see RL8
		else $error("data not released after strobe");
	hold_request_a: assert property (($rose(s_q.mst == M_ARB) && !i_cfg.style_ds)
		|=> o_pin.bus_hold_request) // see RL10
		else $error("hold request missing");
	hold_kept_a: assert property ((s_q.mst inside {M_STRB, M_END} && !i_cfg.style_ds)
		|-> o_pin.bus_hold_request) // see RL11
		else $error("hold dropped during transfer");
	strobe_after_addr_a: assert property ($fell(o_pin.read_strobe_n) || $fell(o_pin.write_strobe_n)
		|| $fell(o_pin.data_strobe_n)
		|-> o_oe.addr && $past(o_oe.addr)) // see RL12
		else $error("strobe before address phase");
	wait_bound_a: assert property ($rose(s_q.mst == M_STRB)
		|-> ##[1:A_WAIT_MAX] s_q.mst == M_END) // see RL13
		else $error("master cycle overran wait timer");
	bad_enable_a: assert property ((s_q.mst == M_IDLE && i_mreq.valid && !map_valid)
		|=> o_mrsp.error && !o_oe.addr) // see RL16
		else $error("invalid byte enables not refused");
	grant_first_a: assert property ($fell(o_pin.data_strobe_n)
		|-> !o_pin.bus_grant_acknowledge_n && o_oe.grant_ack) // see RL19
		else $error("data strobe without bus ownership");

	strobe_cycle_c: cover property (s_q.mst == M_STRB && !i_cfg.style_ds ##1 s_q.mst == M_END);
	ds_cycle_c: cover property (s_q.mst == M_STRB && i_cfg.style_ds ##1 s_q.mst == M_END);
	slave_read_c: cover property (s_q.slv == S_DATA && o_oe.data);
	refused_c: cover property (o_mrsp.done && o_mrsp.error);

endmodule : plb_bridge
`default_nettype wire

// *** bench/plb_local_side.sv ***
// Far side of the local bus: peripheral, hold and grant arbiter, processor lines.
// Assumes plb_pkg and pins seen through the bridge's output enables.
`timescale 1ns/1ps
`default_nettype none
module plb_local_side (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire plb_pkg::plb_pin_out_t i_pout,
	input wire plb_pkg::plb_pin_oe_t i_oe,
	input wire plb_pkg::plb_pin_in_t i_cpu,
	input wire logic i_cpu_drv,
	input wire logic [3:0] i_rdy_dly,
	output plb_pkg::plb_pin_in_t o_pin
);
	import plb_pkg::*;
	logic [3:0] cnt_q;
	logic hlda_q;
	logic [15:0] last_q;
	logic act;
	logic rdy;
	// A master cycle is open while the bridge holds a strobe low
	assign act = (i_oe.strobe_cmd && !(i_pout.read_strobe_n && i_pout.write_strobe_n))
		|| (i_oe.ds_cmd && !i_pout.data_strobe_n);
	// Delay 15 never answers, so the bridge must end on its own timer
	assign rdy = act && cnt_q >= i_rdy_dly && i_rdy_dly != 4'hF;
	// Strobe counter, hold acknowledge one cycle behind hold, last bus level
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 4'h0;
			hlda_q <= 1'b0;
			last_q <= 16'h0000;
		end else begin
			cnt_q <= act ? cnt_q + 4'h1 : 4'h0;
			hlda_q <= i_pout.bus_hold_request;
			last_q <= o_pin.local_data_lines;
		end
	end
	// Merge of all drivers; a free data bus shows the inverse of its last level
	always_comb begin
		o_pin = i_cpu;
		o_pin.bus_hold_acknowledge = hlda_q;
		o_pin.bus_grant_in_n = i_pout.bus_request_out_n;
		o_pin.bus_grant_acknowledge_n = !i_oe.grant_ack || i_pout.bus_grant_acknowledge_n;
		o_pin.cycle_ready_n = i_oe.cycle_ready ? i_pout.cycle_ready_n : !(rdy && i_oe.strobe_cmd);
		o_pin.data_acknowledge_n = i_oe.data_ack ? i_pout.data_acknowledge_n : !(rdy && i_oe.ds_cmd);
		if (i_oe.strobe_cmd) begin
			o_pin.read_strobe_n = i_pout.read_strobe_n;
			o_pin.write_strobe_n = i_pout.write_strobe_n;
		end
		if (i_oe.ds_cmd) begin
			o_pin.data_strobe_n = i_pout.data_strobe_n;
		end
		if (i_oe.addr) begin
			o_pin.local_address_lines = i_pout.local_address_lines;
			o_pin.read_write_direction = i_pout.read_write_direction;
		end
		if (i_oe.data) begin
			o_pin.local_data_lines = i_pout.local_data_lines;
		end else if (act && (i_oe.strobe_cmd ? !i_pout.read_strobe_n : i_pout.read_write_direction)) begin
			o_pin.local_data_lines = {4'hA, i_pout.local_address_lines};
		end else if (!i_cpu_drv) begin
			o_pin.local_data_lines = ~last_q;
		end
	end
endmodule : plb_local_side
`default_nettype wire

// *** bench/test_pci_local_bus_bridge.sv ***
// Bench for the local bus bridge: master accesses in both styles and widths,
// refusals, wait timer, slave register cycles. Assumes plb_local_side.
`timescale 1ns/1ps
`default_nettype none
module test_pci_local_bus_bridge;
	import plb_pkg::*;
	typedef struct packed {
		logic err;
		logic rd;
		logic [31:0] rdata;
		logic [11:0] la;
		logic b0;
		logic sz;
		logic [15:0] d;
		logic [15:0] m;
		logic [1:0] pg;
	} plb_exp_t;
	localparam time DLY = 2;
	logic i_clk;
	logic i_rst_n;
	logic cpu_drv;
	logic seen = 1'b0;
	logic local_clock_out;
	logic [3:0] rdy_dly;
	logic [3:0] pats [6] = '{BE_B0, BE_B1, BE_B2, BE_B3, BE_H0, BE_H2};
	plb_cfg_t cfg;
	plb_mreq_t mreq;
	plb_mrsp_t mrsp;
	plb_rreq_t rreq;
	plb_rrsp_t rrsp = '0;
	plb_pin_in_t pin_in;
	plb_pin_in_t cpu;
	plb_pin_out_t pout;
	plb_pin_out_t snap;
	plb_pin_oe_t oe;
	plb_exp_t mq[$];
	logic [28:0] sq[$];
	int miscompares = 0;
	int total_checks = 0;
	int seed;
	plb_bridge DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_mreq(mreq), .o_mrsp(mrsp),
		.o_rreq(rreq), .i_rrsp(rrsp), .i_pin(pin_in), .o_pin(pout), .o_oe(oe),
		.o_local_clock_out(local_clock_out));
	plb_local_side u_side (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pout(pout), .i_oe(oe),
		.i_cpu(cpu), .i_cpu_drv(cpu_drv), .i_rdy_dly(rdy_dly), .o_pin(pin_in));
	// 20 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic chk(input bit c, input string s);
		total_checks++;
		if (!c) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, s);
		end
	endtask : chk
	task automatic tick();
		@(posedge i_clk);
		#DLY;
	endtask : tick
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// Expected pins and result of one window access under the present settings
	function automatic plb_exp_t mk(input logic wr, input logic [14:0] a, input logic [3:0] be,
		input logic [31:0] w);
		plb_exp_t e;
		logic [1:0] ix;
		logic half;
		logic hi;
		logic swap;
		logic [15:0] r;
		logic [15:0] h;
		ix = (be == 4'hE || be == 4'hC) ? 2'h0 : (be == 4'hD) ? 2'h1 : (be == 4'h7) ? 2'h3 : 2'h2;
		half = be == 4'hC || be == 4'h3;
		e.err = !(cfg.local_master_enable_bit && cfg.second_window_enable_bit && a[14:13] != 2'h3
			&& (be inside {4'hE, 4'hD, 4'hB, 4'h7} || (half && cfg.port16)));
		e.rd = !wr;
		hi = cfg.style_ds ^ (cfg.port16 && ix[0]);
		swap = half && cfg.style_ds && !cfg.swap_dis;
		e.sz = !half && (cfg.style_ds || !hi);
		e.la = {a[12:2], ix[1]};
		e.b0 = ix[0];
		e.pg = (a[14:13] == 2'h0) ? 2'h2 : (a[14:13] == 2'h1) ? 2'h1 : 2'h0;
		h = w[16 * ix[1] +: 16];
		e.d = half ? (swap ? {h[7:0], h[15:8]} : h)
			: (hi ? {w[8 * ix +: 8], 8'h00} : {8'h00, w[8 * ix +: 8]});
		e.m = !wr ? 16'h0000 : half ? 16'hFFFF : hi ? 16'hFF00 : 16'h00FF;
		r = {4'hA, e.la};
		r = swap ? {r[7:0], r[15:8]} : r;
		e.rdata = half ? ({16'h0000, r} << (16 * ix[1]))
			: ({24'h000000, hi ? r[15:8] : r[7:0]} << (8 * ix));
		return e;
	endfunction : mk
	task automatic mcyc(input logic wr, input logic [14:0] a, input logic [3:0] be,
		input logic [31:0] w);
		int n;
		mq.push_back(mk(wr, a, be, w));
		mreq = '{valid: 1'b1, write: wr, addr: a, be_n: be, wdata: w};
		tick();
		mreq.valid = 1'b0;
		chk(mrsp.busy === !mq[$].err, "busy");
		for (n = 0; n < 300 && mrsp.done !== 1'b1; n++) tick();
		chk(n < 300, "master access hung");
		tick();
	endtask : mcyc
	// Ready or acknowledge of the slave side as {driven, level}
	function automatic logic [1:0] rdy();
		return cfg.style_ds ? {oe.data_ack, pout.data_acknowledge_n}
			: {oe.cycle_ready, pout.cycle_ready_n};
	endfunction : rdy
	task automatic scyc(input logic wr, input logic [11:0] a, input logic [15:0] d);
		int n;
		sq.push_back({wr, a, wr ? d : 16'h0000});
		cpu.local_address_lines = a;
		cpu.local_data_lines = d;
		cpu.read_write_direction = !wr;
		cpu.slave_chip_select_n = 1'b0;
		cpu_drv = wr;
		tick();
		if (cfg.style_ds) cpu.data_strobe_n = 1'b0;
		else if (wr) cpu.write_strobe_n = 1'b0;
		else cpu.read_strobe_n = 1'b0;
		for (n = 0; n < 40 && rdy() !== 2'h2; n++) tick();
		chk(n < 40, "slave never ready");
		if (!wr) chk(oe.data === 1'b1 && pout.local_data_lines === {4'h5, a}, "slave data");
		cpu.read_strobe_n = 1'b1;
		cpu.write_strobe_n = 1'b1;
		cpu.data_strobe_n = 1'b1;
		cpu_drv = 1'b0;
		for (n = 0; n < 10 && (rdy() !== 2'h3 || oe.data !== 1'b0); n++) tick();
		chk(n < 10, "slave not released");
	endtask : scyc
	// Register file answers one cycle after each request
	always @(posedge i_clk) begin
		rrsp.ack <= rreq.valid;
		rrsp.rdata <= {4'h5, rreq.addr};
	end
	// Snapshots each local cycle and compares every result with the oldest note
	always @(posedge i_clk) begin : mon
		plb_exp_t e;
		logic [28:0] s;
		if ((oe.strobe_cmd && !(pout.read_strobe_n && pout.write_strobe_n))
			|| (oe.ds_cmd && !pout.data_strobe_n)) begin
			snap = pout;
			seen = 1'b1;
		end
		if (rreq.valid === 1'b1) begin
			s = sq.pop_front();
			chk({rreq.write, rreq.addr} === s[28:16] && (!s[28] || rreq.wdata === s[15:0]), "reg");
		end
		if (mrsp.done === 1'b1) begin
			e = mq.pop_front();
			chk(mrsp.error === e.err, "error flag");
			if (e.err) begin
				chk(seen === 1'b0, "cycle when refused");
			end else begin
				chk(seen === 1'b1, "no cycle");
				chk({snap.local_address_lines, snap.local_address_bit0} === {e.la, e.b0}, "addr");
				chk({snap.page_select_two, snap.page_select_one} === e.pg, "page");
				chk((cfg.style_ds ? snap.transfer_size_bit : snap.byte_high_enable_n) === e.sz, "size");
				chk((cfg.style_ds ? snap.read_write_direction : !snap.read_strobe_n) === e.rd, "dir");
				chk((snap.local_data_lines & e.m) === (e.d & e.m), "write lane");
				chk((cfg.style_ds ? !snap.bus_grant_acknowledge_n : snap.bus_hold_request) === 1'b1, "hold");
				chk(!e.rd || mrsp.rdata === e.rdata, "read lane");
			end
			seen = 1'b0;
		end
	end
	// Cuts a hang short, far beyond the thousand or so cycles the tests need
	initial begin
		#1000000;
		miscompares++;
		give_verdict();
	end
	// Main sequence
	initial begin
		int n;
		cfg = 5'h00;
		mreq = '0;
		cpu = '1;
		cpu_drv = 1'b0;
		rdy_dly = 4'h2;
		i_rst_n = 1'b0;
		seed = $urandom(32'hA86A);
		repeat (3) @(posedge i_clk);
		#DLY i_rst_n = 1'b1;
		tick();
		chk(local_clock_out === i_clk, "clock out");
		cfg = 5'h08;
		mcyc(1'b1, 15'h0000, 4'hE, 32'h12345678);
		cfg = 5'h10;
		mcyc(1'b0, 15'h0000, 4'hE, 32'h0);
		cfg = 5'h18;
		mcyc(1'b1, 15'h6000, 4'hE, 32'h0);
		mcyc(1'b1, 15'h0000, 4'h5, 32'h0);
		for (int m = 0; m < 5; m++) begin
			cfg = (m < 4) ? (5'h18 | 5'(m << 1)) : 5'h1F;
			repeat (30) tick();
			for (int k = 0; k < 12; k++) begin
				rdy_dly = 4'($urandom_range(1, 4));
				mcyc(1'(k / 6), {2'($urandom_range(0, 2)), 11'($urandom), 2'h0},
					pats[k % 6], $urandom);
			end
		end
		rdy_dly = 4'hF;
		mcyc(1'b1, 15'h2000, 4'hC, 32'hCAFEF00D);
		rdy_dly = 4'h2;
		for (int m = 0; m < 2; m++) begin
			cfg.style_ds = 1'(m);
			repeat (30) tick();
			scyc(1'b0, 12'h123, 16'h0000);
			scyc(1'b1, 12'h456, 16'($urandom));
			scyc(1'b0, 12'h456, 16'h0000);
			cpu.slave_chip_select_n = 1'b1;
			for (n = 0; n < 10 && (oe.cycle_ready | oe.data_ack) !== 1'b0; n++) tick();
			chk(n < 10, "ready still driven");
		end
		tick();
		chk(mq.size() == 0 && sq.size() == 0, "results missing");
		give_verdict();
	end
endmodule : test_pci_local_bus_bridge
`default_nettype wire
